// file: dmb_pkg.sv
// Constants and types for the direct-mode bit interface
//
// Summary of operation
// - Direct mode routes input pin bits to the modulator, no packet FIFO.
// - Clock select: 00 none, 01 GPIO, 10 SPI data-out, 11 interrupt pin.
// - Invert bit set: every transmit data bit is inverted before modulation.
// - GFSK needs the bit clock output; FSK needs only the data input.
// - Receive direct mode drives demodulated bits and optional bit clock in real time.
// - After preamble detection, bit timing switches to packet tracking behaviour.
// - Synchronous transmit drives a square bit clock at the programmed rate.
// - Synchronous transmit supports FSK, GFSK and OOK.
// - Asynchronous transmit: no bit clock, data taken at any rate.
// - Asynchronous transmit samples data input at the full internal rate.
// - Asynchronous mode allows carrier, FSK and OOK, never GFSK.
// - SPI data-out carries read data when selected, bit clock otherwise if 10.
// - Clock select 11 uses the interrupt pin only with no interrupt enabled.
// - Source 01, deselected: SPI data-in is modulation input or receive output.
// - SPI data-out not a clock: GPIO config bit 3 makes it the interrupt.
// - Pseudorandom mode generates transmit bits internally from PN9.
// - Source select: 00 GPIO, 01 SPI data-in, 10 FIFO, 11 PN9.
// - Modulation: 00 carrier, 01 OOK, 10 FSK, 11 GFSK.
package dmb_pkg;

  localparam logic [1:0] DMB_CLK_NONE  = 2'h0;
  localparam logic [1:0] DMB_CLK_GPIO  = 2'h1;
  localparam logic [1:0] DMB_CLK_SDO   = 2'h2;
  localparam logic [1:0] DMB_CLK_IRQ   = 2'h3;
  localparam logic [1:0] DMB_SRC_GPIO  = 2'h0;
  localparam logic [1:0] DMB_SRC_SDI   = 2'h1;
  localparam logic [1:0] DMB_SRC_FIFO  = 2'h2;
  localparam logic [1:0] DMB_SRC_PN9   = 2'h3;
  localparam logic [1:0] DMB_MOD_CW    = 2'h0;
  localparam logic [1:0] DMB_MOD_OOK   = 2'h1;
  localparam logic [1:0] DMB_MOD_FSK   = 2'h2;
  localparam logic [1:0] DMB_MOD_GFSK  = 2'h3;
  localparam logic [8:0] DMB_PN9_SEED  = 9'h1ff;
  localparam int         DMB_PN9_TAP   = 4;
  localparam int         DMB_FIFO_W    = 1;
  localparam int         DMB_FIFO_D    = 16;
  localparam int         DMB_CNT_W     = 16;

  typedef enum logic [1:0] {DMB_IDLE, DMB_TX_SYNC, DMB_TX_ASYNC, DMB_RX} dmb_mode_t;

  typedef struct packed {
    logic [1:0] clk_sel;
    logic [1:0] src_sel;
    logic [1:0] mod_type;
    logic       invert;
    logic       tx_on;
    logic       rx_on;
    logic       sdo_irq_en;
    logic       irq_any_en;
  } dmb_cfg_t;

  typedef struct packed {
    logic sdo_out;
    logic sdo_oe;
    logic sdi_out;
    logic sdi_oe;
    logic interrupt_out_n;
    logic gpio_clk;
    logic gpio_rx_data;
  } dmb_pins_t;

endpackage

// file: dmb_fifo.sv
// Parameterised valid/ready FIFO for transmit bits toward the modulator
`timescale 1ns/10ps
module dmb_fifo
  import dmb_pkg::*;
#(
  parameter int WIDTH = DMB_FIFO_W,
  parameter int DEPTH = DMB_FIFO_D
)
(
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0]   cnt;
  } dmb_fifo_st_t;

  dmb_fifo_st_t     st_r;
  dmb_fifo_st_t     st_nxt;
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic             do_wr;
  logic             do_rd;

  assign in_ready  = (st_r.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_r.cnt != '0);
  assign out_data  = mem_r[st_r.rd];
  assign do_wr     = in_valid && in_ready;
  assign do_rd     = out_valid && out_ready;

  always_comb
  begin
    st_nxt = st_r;
    if (do_wr)
      st_nxt.wr = (st_r.wr == AW'(DEPTH-1)) ? '0 : st_r.wr + 1'b1;
    if (do_rd)
      st_nxt.rd = (st_r.rd == AW'(DEPTH-1)) ? '0 : st_r.rd + 1'b1;
    case ({do_wr, do_rd})
      2'b10:   st_nxt.cnt = st_r.cnt + 1'b1;
      2'b01:   st_nxt.cnt = st_r.cnt - 1'b1;
      default: st_nxt.cnt = st_r.cnt;
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // Storage has no reset; only the pointers and count need a defined start
  always_ff @(posedge clock)
  begin
    if (do_wr)
      mem_r[st_r.wr] <= in_data;
  end

  a_fifo_no_over : assert property (@(posedge clock) disable iff (rst)
    st_r.cnt <= (AW+1)'(DEPTH))
    else $error("fifo count above depth");

endmodule

// file: dmb_direct.sv
// Direct-mode bit interface: pin muxing, bit clock, PN9 and receive output
`timescale 1ns/10ps
module dmb_direct
  import dmb_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire dmb_cfg_t             cfg,
  input  wire logic [DMB_CNT_W-1:0] bit_half_period,
  input  wire logic                 chip_select_n,
  input  wire logic                 sdi_in,
  input  wire logic                 gpio_tx_data,
  input  wire logic                 spi_read_data,
  input  wire logic                 irq_request_n,
  input  wire logic                 rx_bit_in,
  input  wire logic                 rx_bit_stb,
  input  wire logic                 preamble_det,
  input  wire logic                 sync_det,
  input  wire logic                 skip_sync,
  input  wire logic                 mod_ready,
  output logic                      mod_valid,
  output logic                      mod_bit,
  output logic [1:0]                mod_type,
  output dmb_pins_t                 pins,
  output logic                      direct_active,
  output logic                      track_packet,
  output logic                      track_optimal,
  output logic                      tx_overrun
);

  typedef struct packed {
    dmb_mode_t            mode;
    logic                 csn_m;
    logic                 csn_s;
    logic                 sdi_m;
    logic                 sdi_s;
    logic                 gpd_m;
    logic                 gpd_s;
    logic                 last_bit;
    logic [DMB_CNT_W-1:0] half_cnt;
    logic                 txclk;
    logic [8:0]           pn9;
    logic                 rxclk;
    logic [DMB_CNT_W-1:0] rx_cnt;
    logic                 rx_bit;
    logic                 pre_seen;
    logic                 sync_seen;
    logic                 track_ok;
    logic [1:0]           mod_type;
    logic                 direct;
    logic                 overrun;
    logic                 mout_valid;
    logic                 mout_bit;
    dmb_pins_t            pins;
  } dmb_state_t;

  dmb_state_t           st_r;
  dmb_state_t           st_nxt;
  logic                 push;
  logic                 push_bit;
  logic                 fifo_ready;
  logic                 fifo_valid;
  logic                 fifo_pop;
  logic [0:0]           fifo_data;
  logic                 src_bit;
  logic                 bitclk;
  logic                 clk_drive;
  logic                 pn9_fb;
  logic [DMB_CNT_W-1:0] half_lim;

  // --------------------------------------------------------------
  // Rate-decoupling buffer toward the modulator
  // --------------------------------------------------------------
  // Output register reloads only when empty or consumed
  assign fifo_pop = fifo_valid && (!st_r.mout_valid || mod_ready);

  dmb_fifo #(
    .WIDTH (DMB_FIFO_W),
    .DEPTH (DMB_FIFO_D)
  ) u_fifo (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   (push_bit),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  // --------------------------------------------------------------
  // Data source selection
  // --------------------------------------------------------------
  assign pn9_fb   = st_r.pn9[8] ^ st_r.pn9[DMB_PN9_TAP];
  assign half_lim = (bit_half_period == '0) ? DMB_CNT_W'(1) : bit_half_period;
  assign bitclk   = cfg.tx_on ? st_r.txclk : st_r.rxclk;
  assign clk_drive = cfg.tx_on || cfg.rx_on;

  always_comb
  begin
    case (cfg.src_sel)
      DMB_SRC_GPIO: src_bit = st_r.gpd_s;
      DMB_SRC_SDI:  src_bit = st_r.sdi_s && st_r.csn_s;
      DMB_SRC_PN9:  src_bit = st_r.pn9[8];
      default:      src_bit = 1'b0;
    endcase
  end

  assign push_bit = src_bit ^ cfg.invert;

  // --------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    push   = 1'b0;

    // Pins are asynchronous to the core clock
    st_nxt.csn_m = chip_select_n;
    st_nxt.csn_s = st_r.csn_m;
    st_nxt.sdi_m = sdi_in;
    st_nxt.sdi_s = st_r.sdi_m;
    st_nxt.gpd_m = gpio_tx_data;
    st_nxt.gpd_s = st_r.gpd_m;

    st_nxt.direct = (cfg.src_sel != DMB_SRC_FIFO);

    // PN9 keeps its own bit timing even without a clock pin
    if (!st_nxt.direct && cfg.src_sel != DMB_SRC_PN9)
      st_nxt.mode = DMB_IDLE;
    else if (cfg.tx_on && (cfg.clk_sel != DMB_CLK_NONE || cfg.src_sel == DMB_SRC_PN9))
      st_nxt.mode = DMB_TX_SYNC;
    else if (cfg.tx_on)
      st_nxt.mode = DMB_TX_ASYNC;
    else if (cfg.rx_on)
      st_nxt.mode = DMB_RX;
    else
      st_nxt.mode = DMB_IDLE;

    // GFSK needs a known bit rate; fall back to FSK without one
    if (st_nxt.mode == DMB_TX_ASYNC && cfg.mod_type == DMB_MOD_GFSK)
      st_nxt.mod_type = DMB_MOD_FSK;
    else
      st_nxt.mod_type = cfg.mod_type;

    case (st_r.mode)
      DMB_TX_SYNC:
      begin
        if (st_r.half_cnt + 1'b1 < half_lim)
          st_nxt.half_cnt = st_r.half_cnt + 1'b1;
        else if (st_r.txclk)
        begin
          st_nxt.half_cnt = '0;
          st_nxt.txclk    = 1'b0;
        end
        else if (fifo_ready)
        begin
          // Bit taken as the clock rises; controller data moves on the fall, PN9 steps here on the rise
          st_nxt.half_cnt = '0;
          st_nxt.txclk    = 1'b1;
          push            = 1'b1;
          if (cfg.src_sel == DMB_SRC_PN9)
            st_nxt.pn9 = {st_r.pn9[7:0], pn9_fb};
        end
      end
      DMB_TX_ASYNC:
      begin
        // Every core cycle is a sample; only level changes are queued
        st_nxt.txclk    = 1'b0;
        st_nxt.half_cnt = '0;
        if (push_bit != st_r.last_bit)
        begin
          if (fifo_ready)
          begin
            push            = 1'b1;
            st_nxt.last_bit = push_bit;
          end
          else
            st_nxt.overrun = 1'b1;
        end
      end
      DMB_RX:
      begin
        st_nxt.txclk = 1'b0;
      end
      default:
      begin
        st_nxt.txclk    = 1'b0;
        st_nxt.half_cnt = '0;
        st_nxt.overrun  = 1'b0;
      end
    endcase

    // Receive: regenerate a bit clock around each demodulated bit
    if (cfg.rx_on && rx_bit_stb)
    begin
      st_nxt.rx_bit = rx_bit_in;
      st_nxt.rxclk  = 1'b1;
      st_nxt.rx_cnt = '0;
    end
    else if (st_r.rxclk && st_r.rx_cnt + 1'b1 < half_lim)
      st_nxt.rx_cnt = st_r.rx_cnt + 1'b1;
    else
      st_nxt.rxclk = 1'b0;

    // Timing recovery changes once a preamble is in
    if (!cfg.rx_on)
    begin
      st_nxt.pre_seen  = 1'b0;
      st_nxt.sync_seen = 1'b0;
    end
    else
    begin
      if (preamble_det)
        st_nxt.pre_seen = 1'b1;
      if (sync_det)
        st_nxt.sync_seen = 1'b1;
    end
    // Without skip-sync a sync-less packet never gets full tracking
    st_nxt.track_ok = st_nxt.pre_seen && (st_nxt.sync_seen || skip_sync);

    // Modulator output stage
    if (fifo_pop)
    begin
      st_nxt.mout_valid = 1'b1;
      st_nxt.mout_bit   = fifo_data[0];
    end
    else if (mod_ready)
      st_nxt.mout_valid = 1'b0;

    // Pin multiplexing
    st_nxt.pins.gpio_clk = (cfg.clk_sel == DMB_CLK_GPIO) && clk_drive && bitclk;
    st_nxt.pins.gpio_rx_data = cfg.rx_on && st_r.rx_bit;

    if (!st_r.csn_s)
    begin
      st_nxt.pins.sdo_out = spi_read_data;
      st_nxt.pins.sdo_oe  = 1'b1;
    end
    else if (cfg.clk_sel == DMB_CLK_SDO && clk_drive)
    begin
      st_nxt.pins.sdo_out = bitclk;
      st_nxt.pins.sdo_oe  = 1'b1;
    end
    else if (cfg.sdo_irq_en)
    begin
      st_nxt.pins.sdo_out = irq_request_n;
      st_nxt.pins.sdo_oe  = 1'b1;
    end
    else
    begin
      st_nxt.pins.sdo_out = 1'b0;
      st_nxt.pins.sdo_oe  = 1'b0;
    end

    if (cfg.clk_sel == DMB_CLK_IRQ && !cfg.irq_any_en && clk_drive)
      st_nxt.pins.interrupt_out_n = bitclk;
    else
      st_nxt.pins.interrupt_out_n = irq_request_n;

    // SPI data-in turns around only while deselected and receiving
    st_nxt.pins.sdi_oe  = (cfg.src_sel == DMB_SRC_SDI) && st_r.csn_s && cfg.rx_on && !cfg.tx_on;
    st_nxt.pins.sdi_out = st_nxt.pins.sdi_oe && st_r.rx_bit;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      st_r                      <= '0;
      st_r.csn_m                <= 1'b1;
      st_r.csn_s                <= 1'b1;
      st_r.pn9                  <= DMB_PN9_SEED;
      st_r.pins.interrupt_out_n <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------
  assign mod_valid     = st_r.mout_valid;
  assign mod_bit       = st_r.mout_bit;
  assign mod_type      = st_r.mod_type;
  assign pins          = st_r.pins;
  assign direct_active = st_r.direct;
  assign track_packet  = st_r.pre_seen;
  assign track_optimal = st_r.track_ok;
  assign tx_overrun    = st_r.overrun;

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_sdo_spi_read : assert property (
    !st_r.csn_s |=> (pins.sdo_oe && pins.sdo_out == $past(spi_read_data)))
    else $error("sdo not carrying spi read data");

  a_sdo_bit_clock : assert property (
    (st_r.csn_s && cfg.clk_sel == DMB_CLK_SDO && cfg.tx_on && !cfg.sdo_irq_en)
      |=> (pins.sdo_out == $past(st_r.txclk)))
    else $error("sdo not carrying bit clock");

  a_irq_clock_gate : assert property (
    cfg.irq_any_en |=> (pins.interrupt_out_n == $past(irq_request_n)))
    else $error("interrupt pin used as clock with interrupts enabled");

  a_gpio_clock_sel : assert property (
    (cfg.clk_sel != DMB_CLK_GPIO) |=> !pins.gpio_clk)
    else $error("gpio clock driven when not selected");

  a_async_no_gfsk : assert property (
    (st_r.mode == DMB_TX_ASYNC) |-> (st_r.mod_type != DMB_MOD_GFSK))
    else $error("gfsk in asynchronous mode");

  a_async_no_clock : assert property (
    (st_r.mode == DMB_TX_ASYNC) [*2] |-> !st_r.txclk)
    else $error("bit clock toggling in asynchronous mode");

  // Pin reaches the capture point two synchroniser stages later
  a_invert_data : assert property (
    (push && cfg.src_sel == DMB_SRC_GPIO && !$past(rst, 2))
      |-> (push_bit == ($past(gpio_tx_data, 2) ^ cfg.invert)))
    else $error("transmit bit inversion wrong");

  a_capture_rise : assert property (
    (push && st_r.mode == DMB_TX_SYNC) |=> $rose(st_r.txclk))
    else $error("sync capture not on rising clock");

  a_clock_steady : assert property (
    (st_r.mode == DMB_TX_SYNC && st_r.half_cnt + 1'b1 < half_lim && st_nxt.mode == DMB_TX_SYNC)
      |=> $stable(st_r.txclk))
    else $error("bit clock changed mid half period");

  a_pn9_step : assert property (
    (push && cfg.src_sel == DMB_SRC_PN9)
      |=> (st_r.pn9 == {$past(st_r.pn9[7:0]), $past(st_r.pn9[8] ^ st_r.pn9[4])}))
    else $error("pn9 step wrong");

  a_rx_data_out : assert property (
    (cfg.rx_on && rx_bit_stb) |=> st_r.rx_bit == $past(rx_bit_in) ##1 pins.gpio_rx_data == $past(st_r.rx_bit))
    else $error("receive bit not presented");

  a_track_switch : assert property (
    (cfg.rx_on && preamble_det) |=> track_packet)
    else $error("tracking not switched after preamble");

  a_sdi_turn : assert property (
    pins.sdi_oe |-> $past(st_r.csn_s && cfg.rx_on))
    else $error("sdi driven while selected or not receiving");

  c_sync_push  : cover property (push && st_r.mode == DMB_TX_SYNC);
  c_async_push : cover property (push && st_r.mode == DMB_TX_ASYNC);
  c_sync_stall : cover property (st_r.mode == DMB_TX_SYNC && !fifo_ready);
  c_rx_bit     : cover property (cfg.rx_on && rx_bit_stb ##1 track_packet);

endmodule

// file: dmb_mcu_model.sv
// Controller model that feeds transmit bits to the direct-mode pins
`timescale 1ns/10ps
module dmb_mcu_model
  import dmb_pkg::*;
(
  input  wire logic rst,
  input  wire logic bit_clk,
  input  wire logic async_mode,
  output logic      tx_data
);
  localparam logic [15:0] PATTERN = 16'hb38d;

  logic        link_clk = 1'b0;
  int unsigned idx      = 0;

  // Controller clock only paces asynchronous data
  always #200 link_clk = ~link_clk;

  always @(posedge rst) idx = 0;

  // Change just after the falling edge, so the next rise sees a settled bit
  always @(negedge bit_clk)
    if (!rst && !async_mode) #1 idx = idx + 1;

  // Own pace: one level change per controller clock
  always @(posedge link_clk)
    if (!rst && async_mode) idx = idx + 1;

  assign tx_data = async_mode ? idx[0] : PATTERN[idx[3:0]];
endmodule

// file: dmb_direct_tb.sv
// Self-checking bench for the direct-mode bit interface
`timescale 1ns/10ps
module dmb_direct_tb
  import dmb_pkg::*;
();
  // ----------------------------------------
  // Harness
  // ----------------------------------------
  localparam logic [15:0] PATTERN = 16'hb38d;

  logic       clock = 1'b0;
  logic       rst = 1'b1;
  dmb_cfg_t   cfg = '0;
  logic       chip_select_n = 1'b1, spi_read_data = 1'b0, irq_request_n = 1'b1;
  logic       rx_bit_in = 1'b0, rx_bit_stb = 1'b0, preamble_det = 1'b0, sync_det = 1'b0;
  logic       mod_ready = 1'b1;
  logic       skip_sync = 1'b0;
  logic [15:0] half_period = 16'h0006;
  logic       mod_valid, mod_bit, direct_active, track_packet, track_optimal, tx_overrun;
  logic       tx_data, bit_clk, watch, sdi_wire;
  logic [1:0] mod_type;
  logic [1:0] wsel = 2'h0;
  dmb_pins_t  pins;
  logic       got[$];
  int         fail_count = 0, samples_checked = 0, rises = 0, highs = 0;

  always #25 clock = ~clock;

  // Shared data-in wire: the device drives it only while enabled
  assign sdi_wire = pins.sdi_oe ? pins.sdi_out : tx_data;
  assign bit_clk  = (cfg.clk_sel == DMB_CLK_SDO) ? pins.sdo_out : pins.gpio_clk;
  assign watch    = (wsel == 2'h0) ? pins.gpio_clk :
                    (wsel == 2'h1) ? pins.sdo_out : pins.interrupt_out_n;

  always @(posedge watch) rises++;
  always @(posedge clock) if (watch === 1'b1) highs++;
  always @(posedge clock) if (mod_valid === 1'b1 && mod_ready === 1'b1) got.push_back(mod_bit);

  dmb_direct i_dut (
    .clock           (clock),
    .rst             (rst),
    .cfg             (cfg),
    .bit_half_period (half_period),
    .chip_select_n   (chip_select_n),
    .sdi_in          (sdi_wire),
    .gpio_tx_data    (tx_data),
    .spi_read_data   (spi_read_data),
    .irq_request_n   (irq_request_n),
    .rx_bit_in       (rx_bit_in),
    .rx_bit_stb      (rx_bit_stb),
    .preamble_det    (preamble_det),
    .sync_det        (sync_det),
    .skip_sync       (skip_sync),
    .mod_ready       (mod_ready),
    .mod_valid       (mod_valid),
    .mod_bit         (mod_bit),
    .mod_type        (mod_type),
    .pins            (pins),
    .direct_active   (direct_active),
    .track_packet    (track_packet),
    .track_optimal   (track_optimal),
    .tx_overrun      (tx_overrun)
  );

  dmb_mcu_model i_mcu (
    .rst        (rst),
    .bit_clk    (bit_clk),
    .async_mode (cfg.clk_sel == DMB_CLK_NONE && cfg.src_sel != DMB_SRC_PN9),
    .tx_data    (tx_data)
  );

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    if (fail_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // New settings only under reset, so no stray clock edge reaches the model
  task automatic restart(input dmb_cfg_t c);
    rst = 1'b1;
    cfg = c;
    step(4);
    rst = 1'b0;
    got.delete();
    step(1);
  endtask

  task automatic wait_bits(input int n);
    int t;
    t = 0;
    while (got.size() < n && t < 4000)
    begin
      @(posedge clock);
      t++;
    end
    #2;
    check("bit count", 16'(n), 16'(got.size()));
  endtask

  function automatic dmb_cfg_t mk(input logic [1:0] c, s, m, input logic inv, tx, rx);
    return {c, s, m, inv, tx, rx, 2'b00};
  endfunction

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    dmb_cfg_t   c;
    logic [1:0] m;
    logic       inv;
    logic [8:0] lfsr;
    logic [15:0] nrise;
    step(3);
    check("irq pin in reset", 1, pins.interrupt_out_n);
    check("mod_valid in reset", 0, mod_valid);
    for (int i = 0; i < 4; i++)
    begin
      m = 2'(i);
      inv = m[0];
      restart(mk(DMB_CLK_GPIO, DMB_SRC_GPIO, m, inv, 1'b1, 1'b0));
      wait_bits(20);
      check("mod_type", m, mod_type);
      check("direct_active", 1, direct_active);
      for (int j = 0; j < 20; j++)
        check("sync bit", PATTERN[j % 16] ^ inv, got[j]);
    end
    restart(mk(DMB_CLK_SDO, DMB_SRC_SDI, DMB_MOD_GFSK, 1'b0, 1'b1, 1'b0));
    wait_bits(16);
    for (int j = 0; j < 16; j++)
      check("sdi bit", PATTERN[j], got[j]);
    chip_select_n = 1'b0;
    for (int v = 0; v < 2; v++)
    begin
      spi_read_data = v[0];
      step(4);
      check("sdo read data", {v[0], 1'b1}, {pins.sdo_out, pins.sdo_oe});
    end
    chip_select_n = 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      wsel = 2'((k > 2) ? 2 : k);
      half_period = (k == 1) ? 16'h0004 : 16'h0006;
      nrise = (k == 3) ? 16'd0 : (k == 1) ? 16'd30 : 16'd20;
      c = mk(2'((k > 2) ? 3 : k + 1), DMB_SRC_GPIO, DMB_MOD_FSK, 1'b0, 1'b1, 1'b0);
      c.irq_any_en = (k == 3);
      restart(c);
      step(24);
      rises = 0;
      highs = 0;
      step(240);
      check("clock rises", nrise, 16'(rises));
      check("clock high cycles", (k == 3) ? 16'd240 : 16'd120, 16'(highs));
    end
    wsel = 2'h0;
    mod_ready = 1'b0;
    restart(mk(DMB_CLK_GPIO, DMB_SRC_GPIO, DMB_MOD_FSK, 1'b0, 1'b1, 1'b0));
    step(600);
    rises = 0;
    step(200);
    check("stalled clock rises", 0, 16'(rises));
    mod_ready = 1'b1;
    wait_bits(24);
    for (int j = 0; j < 24; j++)
      check("bit after stall", PATTERN[j % 16], got[j]);
    for (int i = 1; i < 4; i++)
    begin
      m = 2'(i);
      restart(mk(DMB_CLK_NONE, DMB_SRC_GPIO, m, 1'b0, 1'b1, 1'b0));
      rises = 0;
      wait_bits(6);
      check("async mod_type", (m == DMB_MOD_GFSK) ? DMB_MOD_FSK : m, mod_type);
      check("async clock rises", 0, 16'(rises));
      for (int j = 0; j < 5; j++)
        check("async level", !got[j], got[j + 1]);
    end
    check("overrun clear", 0, tx_overrun);
    mod_ready = 1'b0;
    step(400);
    check("overrun set", 1, tx_overrun);
    mod_ready = 1'b1;
    c = mk(DMB_CLK_NONE, DMB_SRC_GPIO, DMB_MOD_FSK, 1'b0, 1'b0, 1'b0);
    c.sdo_irq_en = 1'b1;
    restart(c);
    for (int v = 0; v < 2; v++)
    begin
      irq_request_n = v[0];
      step(4);
      check("sdo interrupt", v[0], pins.sdo_out);
    end
    restart(mk(DMB_CLK_GPIO, DMB_SRC_SDI, DMB_MOD_FSK, 1'b0, 1'b0, 1'b1));
    for (int v = 0; v < 4; v++)
    begin
      rx_bit_in = v[0];
      rx_bit_stb = 1'b1;
      step(1);
      rx_bit_stb = 1'b0;
      step(2);
      check("rx pins", {v[0], v[0], 1'b1}, {pins.gpio_rx_data, pins.sdi_out, pins.sdi_oe});
    end
    chip_select_n = 1'b0;
    step(4);
    check("sdi released", 0, pins.sdi_oe);
    chip_select_n = 1'b1;
    check("track idle", 0, track_packet);
    preamble_det = 1'b1;
    step(1);
    preamble_det = 1'b0;
    step(2);
    check("track preamble", 2'b10, {track_packet, track_optimal});
    sync_det = 1'b1;
    step(1);
    sync_det = 1'b0;
    step(2);
    check("track sync", 1, track_optimal);
    skip_sync = 1'b1;
    restart(mk(DMB_CLK_GPIO, DMB_SRC_SDI, DMB_MOD_FSK, 1'b0, 1'b0, 1'b1));
    check("skip without preamble", 0, track_optimal);
    preamble_det = 1'b1;
    step(1);
    preamble_det = 1'b0;
    step(2);
    check("track skip sync", 1, track_optimal);
    skip_sync = 1'b0;
    restart(mk(DMB_CLK_GPIO, DMB_SRC_PN9, DMB_MOD_FSK, 1'b0, 1'b1, 1'b0));
    wait_bits(20);
    lfsr = DMB_PN9_SEED;
    for (int j = 0; j < 20; j++)
    begin
      check("pn9 bit", lfsr[8], got[j]);
      lfsr = {lfsr[7:0], lfsr[8] ^ lfsr[DMB_PN9_TAP]};
    end
    restart(mk(DMB_CLK_GPIO, DMB_SRC_FIFO, DMB_MOD_FSK, 1'b0, 1'b1, 1'b0));
    step(100);
    check("fifo source idle", 2'b00, {direct_active, mod_valid});
    finish_test();
  end

  // Whole run needs some 4100 cycles; this allows about five times that
  initial
  begin
    #1000000;
    fail_count++;
    finish_test();
  end
endmodule
